// *** dv/plic_led_strap.sv ***
// Indicator LEDs and strap resistors sharing the three indicator pins
`timescale 1ns/10ps
module plic_led_strap (
    input wire logic [2:0] strap,
    input wire logic [2:0] pin_drive,
    input wire logic [2:0] pin_oe,
    output logic [2:0] pin_level
);
    // ----------------------------------------------------------------
    // Pad levels
    // ----------------------------------------------------------------
    // Released pad falls to its strap resistor, never to the last driven value
    assign pin_level = (pin_oe & pin_drive) | (~pin_oe & strap);
endmodule // plic_led_strap

// *** dv/plic_top_bench.sv ***
// Self-checking bench for the status indicator block
`timescale 1ns/10ps
module plic_top_bench;
    import plic_pkg::*;
    localparam int HALF = 8;
    localparam int STR = 5;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic link_good, speed_100, full_duplex, tx_active, rx_active, collision;
    logic indicator_mode_select, reg_wr;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [2:0] drv, oe, lvl;
    logic collision_pin_drive, collision_pin_oe, autoneg_enable;
    logic [3:0] adv_ability;
    logic [10:0] msk;
    logic [2:0] strap_sel = 3'h5;
    int fail_count = 0;
    int checked = 0;
    int n;
    // ----------------------------------------------------------------
    // Design and pin partner
    // ----------------------------------------------------------------
    plic_top #(.BLINK_HALF(HALF), .STRETCH(STR), .CNT_W(24)) u_dut (
        .mclk(mclk), .nrst(nrst), .link_good(link_good), .speed_100(speed_100),
        .full_duplex(full_duplex), .tx_active(tx_active), .rx_active(rx_active), .collision(collision),
        .link_indicator_pin_level(lvl[0]), .link_indicator_pin_drive(drv[0]), .link_indicator_pin_oe(oe[0]),
        .rate_indicator_pin_level(lvl[1]), .rate_indicator_pin_drive(drv[1]), .rate_indicator_pin_oe(oe[1]),
        .activity_indicator_pin_level(lvl[2]), .activity_indicator_pin_drive(drv[2]),
        .activity_indicator_pin_oe(oe[2]), .indicator_mode_select(indicator_mode_select),
        .collision_pin_drive(collision_pin_drive), .collision_pin_oe(collision_pin_oe),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .adv_ability(adv_ability), .autoneg_enable(autoneg_enable));
    // Straps: autoneg on, 100 half and full advertised
    plic_led_strap u_pins (.strap(strap_sel), .pin_drive(drv), .pin_oe(oe), .pin_level(lvl));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cycles(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge mclk);
        reg_addr = a;
        @(negedge mclk);
        check(reg_rdata, exp, "register read");
    endtask
    // Order: link, speed, full duplex, tx, rx, collision
    task automatic set_status(input logic [5:0] v);
        @(negedge mclk);
        {link_good, speed_100, full_duplex, tx_active, rx_active, collision} = v;
        cycles(2);
    endtask
    task automatic count_toggles(output int t);
        logic last;
        t = 0;
        last = drv[0];
        repeat (64) begin
            @(negedge mclk);
            if (drv[0] !== last) t++;
            last = drv[0];
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Clock, watchdog, sequence
    // ----------------------------------------------------------------
    initial begin
        forever #50 mclk = ~mclk;
    end
    // Whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        give_verdict();
    end
    initial begin
        {link_good, speed_100, full_duplex, tx_active, rx_active, collision} = 6'h0;
        indicator_mode_select = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        cycles(12);
        check(16'(oe), 16'h0007, "indicator enables");
        check(16'(collision_pin_oe), 16'h0001, "collision enable");
        check(16'(adv_ability), 16'h000c, "strap abilities");
        check(16'(autoneg_enable), 16'h0001, "strap autoneg");
        rd(ADDR_ADV, 16'h0180);
        rd(ADDR_IND_CTL, 16'h0000);
        rd(ADDR_PHY_CTL, 16'h0000);
        rd(ADDR_XIND_CTL, 16'h0000);
        // Mode 2, polarity 0 so on drives low
        set_status(6'b100001);
        check(16'(drv), 16'h0002, "mode 2 low polarity");
        check(16'(collision_pin_drive), 16'h0001, "collision pin");
        wr(ADDR_IND_CTL, 16'hffff);
        rd(ADDR_IND_CTL, 16'h07c0);
        rd(8'h30, 16'h0000);
        wr(ADDR_IND_CTL, 16'h01c0);
        // Mode 1, high bit set too
        wr(ADDR_PHY_CTL, 16'h0060);
        rd(ADDR_PHY_CTL, 16'h0060);
        set_status(6'b110001);
        check(16'(drv), 16'h0003, "mode 1 idle");
        @(negedge mclk);
        tx_active = 1'b1;
        @(negedge mclk);
        tx_active = 1'b0;
        cycles(1);
        check(16'(drv[2]), 16'h0001, "activity pulse");
        cycles(STR + 2);
        check(16'(drv[2]), 16'h0000, "activity released");
        // Mode 3: duplex on activity pin, collision ignored
        wr(ADDR_PHY_CTL, 16'h0040);
        set_status(6'b111000);
        check(16'(drv[2]), 16'h0001, "full duplex");
        set_status(6'b110001);
        check(16'(drv[2]), 16'h0000, "half duplex");
        // Mode 2 blink under steady receive traffic
        wr(ADDR_PHY_CTL, 16'h0000);
        set_status(6'b100010);
        count_toggles(n);
        check(16'(n >= 7 && n <= 9), 16'h0001, "blink at 5Hz");
        wr(ADDR_IND_CTL, 16'h05c0);
        count_toggles(n);
        check(16'(n >= 31 && n <= 33), 16'h0001, "blink at 20Hz");
        wr(ADDR_IND_CTL, 16'h03c0);
        count_toggles(n);
        check(16'(n >= 15 && n <= 17), 16'h0001, "blink at 10Hz");
        wr(ADDR_IND_CTL, 16'h07c0);
        count_toggles(n);
        check(16'(n >= 3 && n <= 5), 16'h0001, "blink at 2.5Hz");
        // Extra indicator routed to the collision pin, codes 0 to 10 except the blink code 8
        wr(ADDR_XIND_CTL, 16'hffff);
        rd(ADDR_XIND_CTL, 16'h007f);
        for (int s = 0; s < 2; s++) begin
            msk = (s == 0) ? 11'h247 : 11'h6bb;
            set_status((s == 0) ? 6'b100100 : 6'b111011);
            for (int c = 0; c < 11; c++) begin
                if (c != 8) begin
                    wr(ADDR_XIND_CTL, 16'(c * 8 + 7));
                    cycles(STR + 2);
                    check(16'(collision_pin_drive), 16'(msk[c]), "extra code");
                end
            end
        end
        // Blink code on an idle good link stays lit
        set_status(6'b100000);
        wr(ADDR_XIND_CTL, 16'h0047);
        cycles(STR + 2);
        check(16'(collision_pin_drive), 16'h0001, "extra blink code idle");
        // Extra indicator on the speed pin hands the collision pin back
        wr(ADDR_XIND_CTL, 16'h0003);
        set_status(6'b100000);
        check(16'(drv[1]), 16'h0001, "extra on speed pin");
        check(16'(collision_pin_drive), 16'h0000, "collision pin back");
        // Second reset: every strap high, mode strap set
        @(negedge mclk);
        nrst = 1'b0;
        strap_sel = 3'h7;
        indicator_mode_select = 1'b1;
        cycles(8);
        check(16'(oe), 16'h0000, "pins released in reset");
        nrst = 1'b1;
        cycles(12);
        check(16'(adv_ability), 16'h000f, "strap abilities all");
        rd(ADDR_PHY_CTL, 16'h0020);
        rd(ADDR_IND_CTL, 16'h0000);
        rd(ADDR_XIND_CTL, 16'h0000);
        give_verdict();
    end
endmodule // plic_top_bench

// *** hw/plic_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for pin levels
`timescale 1ns/10ps
module plic_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_level,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] level_ff;
    // ----------------------------------------------------------------
    // Per-bit chain; first stage feeds only the second
    // ----------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                s1_ff[i] <= 1'b0;
                s2_ff[i] <= 1'b0;
                s3_ff[i] <= 1'b0;
                level_ff[i] <= 1'b0;
            end else begin
                s1_ff[i] <= pin_level[i];
                s2_ff[i] <= s1_ff[i];
                s3_ff[i] <= s2_ff[i];
                // Glitch guard: change only once two stages agree
                if (s2_ff[i] == s3_ff[i]) begin
                    level_ff[i] <= s3_ff[i];
                end
            end
        end
    end
    assign level = level_ff;
endmodule // plic_pin_sync

// *** hw/plic_pkg.sv ***
// Constants and types shared by the indicator control block
package plic_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_ADV = 8'h04;
    localparam logic [7:0] ADDR_IND_CTL = 8'h18;
    localparam logic [7:0] ADDR_PHY_CTL = 8'h19;
    localparam logic [7:0] ADDR_XIND_CTL = 8'h25;
    // ----------------------------------------------------------------
    // Field positions and implemented bits
    // ----------------------------------------------------------------
    localparam int IND_RATE_LO = 9;
    localparam int IND_POL_LO = 6;
    localparam int PHY_MODE_LO = 5;
    localparam int XIND_EN_BIT = 0;
    localparam int XIND_ROUTE_LO = 1;
    localparam int XIND_MODE_LO = 3;
    localparam int ADV_LO = 5;
    localparam logic [15:0] IND_CTL_MASK = 16'h07c0;
    localparam logic [15:0] PHY_CTL_MASK = 16'h0060;
    localparam logic [15:0] XIND_CTL_MASK = 16'h007f;
    localparam logic [15:0] ADV_MASK = 16'h01e0;
    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [15:0] IND_CTL_RST = 16'h0000;
    localparam logic [15:0] PHY_CTL_RST = 16'h0000;
    localparam logic [15:0] XIND_CTL_RST = 16'h0000;
    localparam logic [15:0] ADV_RST = 16'h01e0;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int BLINK_BASE_HZ = 5;
    localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_BASE_HZ);
    localparam int STRETCH_MS = 50;
    localparam int STRETCH_CYC = (CLK_HZ / 1000) * STRETCH_MS;
    localparam int SETTLE_CYC = 4;
    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    localparam logic [1:0] RATE_5HZ = 2'h0;
    localparam logic [1:0] RATE_10HZ = 2'h1;
    localparam logic [1:0] RATE_20HZ = 2'h2;
    localparam logic [1:0] RATE_2HZ5 = 2'h3;
    localparam logic [1:0] ROUTE_LINK = 2'h0;
    localparam logic [1:0] ROUTE_RATE = 2'h1;
    localparam logic [1:0] ROUTE_ACT = 2'h2;
    localparam logic [1:0] ROUTE_COL = 2'h3;
    localparam logic [3:0] XM_LINK = 4'h0;
    localparam logic [3:0] XM_ACT = 4'h1;
    localparam logic [3:0] XM_TX = 4'h2;
    localparam logic [3:0] XM_RX = 4'h3;
    localparam logic [3:0] XM_COL = 4'h4;
    localparam logic [3:0] XM_FAST = 4'h5;
    localparam logic [3:0] XM_SLOW = 4'h6;
    localparam logic [3:0] XM_FDX = 4'h7;
    localparam logic [3:0] XM_BLINK = 4'h8;
    localparam logic [3:0] XM_STRETCH = 4'h9;
    localparam logic [3:0] XM_FFD_LINK = 4'ha;
    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_RUN = 3'b100
    } plic_state_t;
endpackage

// *** hw/plic_top.sv ***
// Status indicator pins, strap capture and indicator registers
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/10ps
module plic_top
    import plic_pkg::*;
#(
    parameter int BLINK_HALF = plic_pkg::BLINK_HALF_CYC,
    parameter int STRETCH = plic_pkg::STRETCH_CYC,
    parameter int CNT_W = 24
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic link_good,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic collision,
    input wire logic link_indicator_pin_level,
    output logic link_indicator_pin_drive,
    output logic link_indicator_pin_oe,
    input wire logic rate_indicator_pin_level,
    output logic rate_indicator_pin_drive,
    output logic rate_indicator_pin_oe,
    input wire logic activity_indicator_pin_level,
    output logic activity_indicator_pin_drive,
    output logic activity_indicator_pin_oe,
    input wire logic indicator_mode_select,
    output logic collision_pin_drive,
    output logic collision_pin_oe,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic [3:0] adv_ability,
    output logic autoneg_enable
);
    import plic_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_a_ff;
    logic rst_n_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_a_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_n_ff <= rst_a_ff;
        end
    end

    // ----------------------------------------------------------------
    // Strap sampling
    // ----------------------------------------------------------------
    logic [3:0] pin_sync;
    plic_pin_sync #(.WIDTH(4)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n_ff),
        .pin_level({indicator_mode_select, activity_indicator_pin_level,
                    rate_indicator_pin_level, link_indicator_pin_level}),
        .level(pin_sync)
    );
    wire strap_low = pin_sync[0];
    wire strap_high = pin_sync[1];
    wire strap_en = pin_sync[2];
    wire strap_mode = pin_sync[3];

    plic_state_t state_ff;
    plic_state_t nxt_state;
    logic [2:0] settle_ff;
    wire settled = (settle_ff == 3'(SETTLE_CYC - 1));
    wire capture = (state_ff == ST_SAMPLE);
    wire running = (state_ff == ST_RUN);
    always_comb begin
        case (state_ff)
            ST_WAIT: nxt_state = settled ? ST_SAMPLE : ST_WAIT;
            ST_SAMPLE: nxt_state = ST_RUN;
            ST_RUN: nxt_state = ST_RUN;
            default: nxt_state = ST_WAIT;
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= ST_WAIT;
            settle_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            settle_ff <= settled ? settle_ff : settle_ff + 3'h1;
        end
    end

    // Pins stay undriven until their strap level is taken
    logic [3:0] strap_adv;
    always_comb begin
        case ({strap_en, strap_high, strap_low})
            3'b000: strap_adv = 4'h1;
            3'b001: strap_adv = 4'h2;
            3'b010: strap_adv = 4'h4;
            3'b011: strap_adv = 4'h8;
            3'b100: strap_adv = 4'h3;
            3'b101: strap_adv = 4'hc;
            3'b110: strap_adv = 4'h5;
            default: strap_adv = 4'hf;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0] ind_ctl_ff;
    logic [15:0] phy_ctl_ff;
    logic [15:0] xind_ctl_ff;
    logic [15:0] adv_ff;
    logic autoneg_strap_enable_ff;
    logic [15:0] rdata_ff;
    wire wr_ind = reg_wr && (reg_addr == ADDR_IND_CTL);
    wire wr_phy = reg_wr && (reg_addr == ADDR_PHY_CTL);
    wire wr_xind = reg_wr && (reg_addr == ADDR_XIND_CTL);
    wire wr_adv = reg_wr && (reg_addr == ADDR_ADV);
    wire [15:0] phy_strapped = {phy_ctl_ff[15:PHY_MODE_LO+1], strap_mode, phy_ctl_ff[PHY_MODE_LO-1:0]};
    wire [15:0] nxt_phy_ctl = capture ? phy_strapped : wr_phy ? (reg_wdata & PHY_CTL_MASK) : phy_ctl_ff;
    wire [15:0] nxt_adv = capture ? {7'h00, strap_adv, 5'h00} : wr_adv ? (reg_wdata & ADV_MASK) : adv_ff;
    wire [15:0] nxt_rdata = (reg_addr == ADDR_IND_CTL) ? ind_ctl_ff :
                            (reg_addr == ADDR_PHY_CTL) ? phy_ctl_ff :
                            (reg_addr == ADDR_XIND_CTL) ? xind_ctl_ff :
                            (reg_addr == ADDR_ADV) ? adv_ff : 16'h0000;
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ind_ctl_ff <= IND_CTL_RST;
            phy_ctl_ff <= PHY_CTL_RST;
            xind_ctl_ff <= XIND_CTL_RST;
            adv_ff <= ADV_RST;
            autoneg_strap_enable_ff <= 1'b1;
            rdata_ff <= 16'h0000;
        end else begin
            ind_ctl_ff <= wr_ind ? (reg_wdata & IND_CTL_MASK) : ind_ctl_ff;
            phy_ctl_ff <= nxt_phy_ctl;
            xind_ctl_ff <= wr_xind ? (reg_wdata & XIND_CTL_MASK) : xind_ctl_ff;
            adv_ff <= nxt_adv;
            autoneg_strap_enable_ff <= capture ? strap_en : autoneg_strap_enable_ff;
            rdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    wire [1:0] blink_rate = ind_ctl_ff[IND_RATE_LO +: 2];
    wire [2:0] pol = ind_ctl_ff[IND_POL_LO +: 3];
    wire mode1 = phy_ctl_ff[PHY_MODE_LO];
    wire mode3 = !phy_ctl_ff[PHY_MODE_LO] && phy_ctl_ff[PHY_MODE_LO+1];
    wire x_en = xind_ctl_ff[XIND_EN_BIT];
    wire [1:0] x_route = xind_ctl_ff[XIND_ROUTE_LO +: 2];
    wire [3:0] x_mode = xind_ctl_ff[XIND_MODE_LO +: 4];

    // ----------------------------------------------------------------
    // Blink and stretch timers
    // ----------------------------------------------------------------
    // Timers run from the core clock so brief bursts stay visible
    logic [CNT_W-1:0] blink_cnt_ff;
    logic blink_ph_ff;
    logic [CNT_W-1:0] stretch_ff;
    wire [CNT_W-1:0] half_base = CNT_W'(BLINK_HALF);
    wire [CNT_W-1:0] half_lim = (blink_rate == RATE_10HZ) ? (half_base >> 1) :
                                (blink_rate == RATE_20HZ) ? (half_base >> 2) :
                                (blink_rate == RATE_2HZ5) ? (half_base << 1) : half_base;
    wire blink_wrap = (blink_cnt_ff >= half_lim - CNT_W'(1));
    wire any_act = tx_active || rx_active;
    wire stretched = (stretch_ff != '0);
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            blink_cnt_ff <= '0;
            blink_ph_ff <= 1'b0;
            stretch_ff <= '0;
        end else begin
            blink_cnt_ff <= blink_wrap ? '0 : blink_cnt_ff + CNT_W'(1);
            blink_ph_ff <= blink_wrap ? !blink_ph_ff : blink_ph_ff;
            stretch_ff <= any_act ? CNT_W'(STRETCH) : stretched ? stretch_ff - CNT_W'(1) : stretch_ff;
        end
    end

    // ----------------------------------------------------------------
    // Indicator functions
    // ----------------------------------------------------------------
    // Link dark for half a blink period while activity persists
    wire link_blink = link_good && !(stretched && blink_ph_ff);
    wire link_on = mode1 ? link_good : link_blink;
    wire rate_on = speed_100;
    wire act_on = mode1 ? stretched : mode3 ? full_duplex : collision;
    logic x_on;
    always_comb begin
        case (x_mode)
            XM_LINK: x_on = link_good;
            XM_ACT: x_on = any_act;
            XM_TX: x_on = tx_active;
            XM_RX: x_on = rx_active;
            XM_COL: x_on = collision;
            XM_FAST: x_on = speed_100;
            XM_SLOW: x_on = !speed_100;
            XM_FDX: x_on = full_duplex;
            XM_BLINK: x_on = link_blink;
            XM_STRETCH: x_on = stretched;
            XM_FFD_LINK: x_on = link_good && speed_100 && full_duplex;
            default: x_on = 1'b0;
        endcase
    end
    // Route: extra indicator takes over one pin when enabled
    wire x_link = x_en && (x_route == ROUTE_LINK);
    wire x_rate = x_en && (x_route == ROUTE_RATE);
    wire x_act = x_en && (x_route == ROUTE_ACT);
    wire x_col = x_en && (x_route == ROUTE_COL);
    // Pin level is on when the polarity bit says on is high
    wire nxt_link_pin = (x_link ? x_on : link_on) ~^ pol[0];
    wire nxt_rate_pin = (x_rate ? x_on : rate_on) ~^ pol[1];
    wire nxt_act_pin = (x_act ? x_on : act_on) ~^ pol[2];
    wire nxt_col_pin = x_col ? x_on : collision;

    logic [2:0] pin_ff;
    logic [2:0] oe_ff;
    logic col_ff;
    logic col_oe_ff;
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pin_ff <= 3'h0;
            oe_ff <= 3'h0;
            col_ff <= 1'b0;
            col_oe_ff <= 1'b0;
        end else begin
            pin_ff <= {nxt_act_pin, nxt_rate_pin, nxt_link_pin};
            oe_ff <= {3{running}};
            col_ff <= nxt_col_pin;
            col_oe_ff <= 1'b1;
        end
    end

    assign link_indicator_pin_drive = pin_ff[0];
    assign rate_indicator_pin_drive = pin_ff[1];
    assign activity_indicator_pin_drive = pin_ff[2];
    assign link_indicator_pin_oe = oe_ff[0];
    assign rate_indicator_pin_oe = oe_ff[1];
    assign activity_indicator_pin_oe = oe_ff[2];
    assign collision_pin_drive = col_ff;
    assign collision_pin_oe = col_oe_ff;
    assign reg_rdata = rdata_ff;
    assign adv_ability = adv_ff[ADV_LO +: 4];
    assign autoneg_enable = autoneg_strap_enable_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_ff);

    chk_rate_pin_speed: assert property (!x_rate |=> rate_indicator_pin_drive == $past(speed_100 ~^ pol[1]))
        else $error("speed pin does not follow line rate");
    chk_link_mode_one: assert property (mode1 && !x_link |=> link_indicator_pin_drive == $past(link_good ~^ pol[0]))
        else $error("mode 1 link pin wrong");
    chk_link_blink_idle: assert property (!mode1 && !x_link && link_good && !stretched && pol[0] |=> link_indicator_pin_drive)
        else $error("idle good link not lit");
    chk_act_stretch_hold: assert property (mode1 && !x_act && pol[2] && any_act ##1 !any_act [*2] |=> activity_indicator_pin_drive)
        else $error("activity pulse not stretched");
    chk_act_collision_mode: assert property (!mode1 && !mode3 && !x_act |=> activity_indicator_pin_drive == $past(collision ~^ pol[2]))
        else $error("mode 2 activity pin not collision");
    chk_act_duplex_mode: assert property (mode3 && !x_act |=> activity_indicator_pin_drive == $past(full_duplex ~^ pol[2]))
        else $error("mode 3 activity pin not duplex");
    chk_pins_float_strap: assert property (!running |=> !link_indicator_pin_oe && !rate_indicator_pin_oe && !activity_indicator_pin_oe)
        else $error("indicator pin driven before strap taken");
    chk_strap_adv_bits: assert property (capture && strap_en && strap_high && strap_low |=> adv_ability == 4'hf)
        else $error("strap not loaded into advertised ability");
    chk_extra_idle_reset: assert property (state_ff == ST_WAIT |-> !x_en && blink_rate == RATE_5HZ)
        else $error("extra indicator or blink rate not at reset value");
    chk_col_taken_over: assert property (x_col && x_mode == XM_FAST |=> collision_pin_drive == $past(speed_100))
        else $error("collision pin not given to extra indicator");
    // Fastest rate holds each phase a quarter of the base half period
    chk_blink_toggle_period: assert property (blink_wrap |-> blink_cnt_ff >= CNT_W'(BLINK_HALF / 4 - 1))
        else $error("blink phase toggles too fast");

    cov_mode_one_act: cover property (mode1 && running && $rose(activity_indicator_pin_drive));
    cov_link_blinks: cover property (!mode1 && running && link_good && stretched && blink_wrap);
    cov_extra_on_col: cover property (x_col && $rose(collision_pin_drive));
    cov_strap_capture: cover property (capture && !strap_en);
endmodule // plic_top
